//--- pvd_image_decode.sv
// PCI-to-VME image decoder: APB register file, two decode images and a forwarding FIFO
//
// Contract
// - An image decodes and forwards only while its enable bit is 1.
// - Width field: 00=8, 01=16, 10=32, 11=64 bits; resets to 10.
// - Space field: A16, A24, A32, CR/CSR, User1, User2; 011 and 100 reserved.
// - Program bit 0 gives data modifier, 1 gives program modifier.
// - Privilege bit 0 gives non-privileged, 1 gives supervisor cycles.
// - Cycle-type bit 0 forbids block transfers, 1 permits them.
// - Cycle-type bit counts only for A24/A32 with 8, 16 or 32-bit width.
// - A24/A32 with 64-bit width may use MBLT regardless of cycle-type bit.
// - Space bit 0 answers PCI memory accesses, 1 answers PCI I/O accesses.
// - Posted writes allowed when set; ignored for I/O images, all coupled.
// - Base field holds address bits 31..16, lowest decoded address.
// - Decode when address at or above base and strictly below bound.
// - Bound of zero means no upper limit above the base.
// - VME address bits 31..16 are PCI bits 31..16 plus offset, modulo.
// - Base, bound and offset resolve in 64 KB steps.
`timescale 1ns/100ps

module pvd_fifo
    import pvd_pkg::*;
#(
    parameter int WIDTH = 32,
    parameter int DEPTH = PVD_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH):0] level
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam logic [PTR_W-1:0] LAST = PTR_W'(DEPTH - 1);
    localparam logic [PTR_W:0] FULL = (PTR_W + 1)'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PTR_W-1:0] wr_ptr;
        logic [PTR_W-1:0] rd_ptr;
        logic [PTR_W:0] count;
    } pvd_fifo_state_t;

    pvd_fifo_state_t state_reg;
    pvd_fifo_state_t state_next;
    logic push;
    logic pop;

    assign in_ready = state_reg.count != FULL;
    assign out_valid = state_reg.count != '0;
    assign out_data = state_reg.mem[state_reg.rd_ptr];
    assign level = state_reg.count;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        state_next = state_reg;
        if (push) begin
            state_next.mem[state_reg.wr_ptr] = in_data;
            // Explicit wrap keeps depths that are not a power of two correct
            state_next.wr_ptr = (state_reg.wr_ptr == LAST) ? '0 : state_reg.wr_ptr + 1'b1;
        end
        if (pop) begin
            state_next.rd_ptr = (state_reg.rd_ptr == LAST) ? '0 : state_reg.rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            state_next.count = state_reg.count + 1'b1;
        end else if (pop && !push) begin
            state_next.count = state_reg.count - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end
endmodule

module pvd_image_decode
    import pvd_pkg::*;
#(
    parameter int FIFO_DEPTH = PVD_FIFO_DEPTH
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pci_valid,
    output logic pci_ready,
    output logic pci_claim,
    input wire logic [31:0] pci_addr,
    input wire logic pci_io_space,
    input wire logic pci_write,
    input wire logic [31:0] pci_wdata,
    output logic vme_valid,
    input wire logic vme_ready,
    output logic [31:0] vme_addr,
    output logic [31:0] vme_wdata,
    output logic vme_write,
    output logic vme_posted,
    output logic [1:0] vme_width,
    output logic [2:0] vme_space,
    output logic vme_program,
    output logic vme_supervisor,
    output logic vme_blt_ok,
    output logic vme_mblt_ok,
    output logic vme_image
);
    localparam int FWD_W = $bits(pvd_fwd_t);
    localparam int LVL_W = $clog2(FIFO_DEPTH) + 1;

    typedef struct packed {
        pvd_img_t [1:0] img;
        logic [31:0] rdata;
        logic [15:0] miss_count;
        logic [1:0] last_hit;
    } pvd_top_state_t;

    localparam pvd_top_state_t TOP_RESET = '{
        img: {PVD_IMG_RESET, PVD_IMG_RESET},
        rdata: 32'h0000_0000,
        miss_count: 16'h0000,
        last_hit: 2'b00
    };

    pvd_top_state_t state_reg;
    pvd_top_state_t state_next;
    logic [1:0] hit;
    logic sel;
    logic any_hit;
    pvd_fwd_t fwd;
    pvd_fwd_t fwd_out;
    logic fifo_in_ready;
    logic [LVL_W-1:0] fifo_level;
    logic [31:0] rd_word;
    logic mapped;
    logic wr_en;

    // Window match for one image
    function automatic logic img_match(pvd_img_t c, logic [31:0] a, logic io);
        logic in_space;
        logic above;
        logic below;
        in_space = (c.pci_space_select == io);
        above = a[31:PVD_HI_LSB] >= c.base;
        below = (c.bound == 16'h0000) || (a[31:PVD_HI_LSB] < c.bound);
        // A reserved space code would put an undefined modifier on the bus, so it claims nothing
        return c.en && in_space && above && below && (c.vme_space_select != PVD_RSV3) && (c.vme_space_select != PVD_RSV4);
    endfunction

    function automatic logic [31:0] ctl_word(pvd_img_t c);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[PVD_CTL_EN_BIT] = c.en;
        w[PVD_CTL_POSTED_WRITE_ON_BIT] = c.posted_write_on;
        w[PVD_CTL_VDW_LSB +: 2] = c.vme_max_width;
        w[PVD_CTL_VAS_LSB +: 3] = c.vme_space_select;
        w[PVD_CTL_PGM_BIT] = c.program_modifier_bit;
        w[PVD_CTL_SUPER_BIT] = c.super_mode;
        w[PVD_CTL_VCT_BIT] = c.block_cycle_allow;
        w[PVD_CTL_LAS_BIT] = c.pci_space_select;
        return w;
    endfunction

    // Decode; image 2 wins an overlap, which software must avoid anyway
    assign hit[0] = img_match(state_reg.img[0], pci_addr, pci_io_space);
    assign hit[1] = img_match(state_reg.img[1], pci_addr, pci_io_space);
    assign any_hit = |hit;
    assign sel = !hit[0];

    always_comb begin
        pvd_img_t c;
        logic a24_a32;
        c = state_reg.img[sel];
        a24_a32 = (c.vme_space_select == PVD_A24) || (c.vme_space_select == PVD_A32);
        fwd.addr = {pci_addr[31:PVD_HI_LSB] + c.xlat, pci_addr[PVD_HI_LSB-1:0]};
        fwd.data = pci_wdata;
        fwd.write = pci_write;
        fwd.posted = pci_write && c.posted_write_on && !c.pci_space_select;
        fwd.width = c.vme_max_width;
        fwd.space = c.vme_space_select;
        fwd.program_am = c.program_modifier_bit;
        fwd.supervisor_am = c.super_mode;
        fwd.blt_ok = a24_a32 && (c.vme_max_width != PVD_W64) && c.block_cycle_allow;
        fwd.mblt_ok = a24_a32 && (c.vme_max_width == PVD_W64);
        fwd.image = sel;
    end

    // Misses are taken at once so the PCI side never stalls on an access nobody claims
    assign pci_claim = any_hit;
    assign pci_ready = !any_hit || fifo_in_ready;

    pvd_fifo #(
        .WIDTH(FWD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(pclk),
        .rst_n(presetn),
        .in_valid(pci_valid && any_hit),
        .in_ready(fifo_in_ready),
        .in_data(fwd),
        .out_valid(vme_valid),
        .out_ready(vme_ready),
        .out_data(fwd_out),
        .level(fifo_level)
    );

    assign vme_addr = fwd_out.addr;
    assign vme_wdata = fwd_out.data;
    assign vme_write = fwd_out.write;
    assign vme_posted = fwd_out.posted;
    assign vme_width = fwd_out.width;
    assign vme_space = fwd_out.space;
    assign vme_program = fwd_out.program_am;
    assign vme_supervisor = fwd_out.supervisor_am;
    assign vme_blt_ok = fwd_out.blt_ok;
    assign vme_mblt_ok = fwd_out.mblt_ok;
    assign vme_image = fwd_out.image;

    // Register read mux
    always_comb begin
        rd_word = 32'h0000_0000;
        mapped = 1'b1;
        if (paddr[1:0] != 2'b00) begin
            mapped = 1'b0;
        end else begin
            unique case (paddr)
                PVD_OFF_IMG2_CTL: rd_word = ctl_word(state_reg.img[0]);
                PVD_OFF_IMG2_BASE: rd_word = {state_reg.img[0].base, 16'h0000};
                PVD_OFF_IMG2_BOUND: rd_word = {state_reg.img[0].bound, 16'h0000};
                PVD_OFF_IMG2_XLAT: rd_word = {state_reg.img[0].xlat, 16'h0000};
                PVD_OFF_IMG3_CTL: rd_word = ctl_word(state_reg.img[1]);
                PVD_OFF_IMG3_BASE: rd_word = {state_reg.img[1].base, 16'h0000};
                PVD_OFF_IMG3_BOUND: rd_word = {state_reg.img[1].bound, 16'h0000};
                PVD_OFF_IMG3_XLAT: rd_word = {state_reg.img[1].xlat, 16'h0000};
                PVD_OFF_STATUS: begin
                    rd_word[PVD_ST_MISS_LSB +: 16] = state_reg.miss_count;
                    rd_word[PVD_ST_LEVEL_LSB +: LVL_W] = fifo_level;
                    rd_word[PVD_ST_HIT_LSB +: 2] = state_reg.last_hit;
                end
                default: mapped = 1'b0;
            endcase
        end
    end

    // Zero wait states; read data is latched in the setup cycle
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = state_reg.rdata;
    assign wr_en = psel && penable && pwrite && mapped;

    always_comb begin
        state_next = state_reg;
        if (psel && !penable) begin
            state_next.rdata = rd_word;
        end
        if (wr_en) begin
            for (int i = 0; i < 2; i++) begin
                if (paddr == (i == 0 ? PVD_OFF_IMG2_CTL : PVD_OFF_IMG3_CTL)) begin
                    state_next.img[i].en = pwdata[PVD_CTL_EN_BIT];
                    state_next.img[i].posted_write_on = pwdata[PVD_CTL_POSTED_WRITE_ON_BIT];
                    state_next.img[i].vme_max_width = pvd_width_t'(pwdata[PVD_CTL_VDW_LSB +: 2]);
                    state_next.img[i].vme_space_select = pvd_space_t'(pwdata[PVD_CTL_VAS_LSB +: 3]);
                    state_next.img[i].program_modifier_bit = pwdata[PVD_CTL_PGM_BIT];
                    state_next.img[i].super_mode = pwdata[PVD_CTL_SUPER_BIT];
                    state_next.img[i].block_cycle_allow = pwdata[PVD_CTL_VCT_BIT];
                    state_next.img[i].pci_space_select = pwdata[PVD_CTL_LAS_BIT];
                end
                // Bits 15..0 are not stored: 64 KB granularity
                if (paddr == (i == 0 ? PVD_OFF_IMG2_BASE : PVD_OFF_IMG3_BASE)) begin
                    state_next.img[i].base = pwdata[31:PVD_HI_LSB];
                end
                if (paddr == (i == 0 ? PVD_OFF_IMG2_BOUND : PVD_OFF_IMG3_BOUND)) begin
                    state_next.img[i].bound = pwdata[31:PVD_HI_LSB];
                end
                if (paddr == (i == 0 ? PVD_OFF_IMG2_XLAT : PVD_OFF_IMG3_XLAT)) begin
                    state_next.img[i].xlat = pwdata[31:PVD_HI_LSB];
                end
            end
        end
        if (pci_valid && pci_ready) begin
            state_next.last_hit = hit[0] ? 2'b01 : (hit[1] ? 2'b10 : 2'b00);
            if (!any_hit) begin
                // Saturates rather than wraps so a flood of misses stays visible
                if (state_reg.miss_count != 16'hFFFF) begin
                    state_next.miss_count = state_reg.miss_count + 16'h0001;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= TOP_RESET;
        end else begin
            state_reg <= state_next;
        end
    end
endmodule

//--- pvd_image_decode_bench.sv
// Testbench: registers, decode windows, translation and queueing of the image decoder
`timescale 1ns/100ps
module pvd_image_decode_bench
    import pvd_pkg::*;
;
    localparam logic [11:0] OFFS [8] = '{PVD_OFF_IMG2_BASE, PVD_OFF_IMG2_BOUND, PVD_OFF_IMG2_XLAT, PVD_OFF_IMG2_CTL,
        PVD_OFF_IMG3_BASE, PVD_OFF_IMG3_BOUND, PVD_OFF_IMG3_XLAT, PVD_OFF_IMG3_CTL};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err_q, vme_ready, vme_valid;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd_q, pci_addr, pci_wdata, vme_addr, vme_wdata;
    logic pci_valid, pci_ready, pci_claim, pci_io_space, pci_write, vme_write, vme_posted;
    logic vme_program, vme_supervisor, vme_blt_ok, vme_mblt_ok, vme_image;
    logic [1:0] vme_width;
    logic [2:0] vme_space;
    int miscompares = 0;
    int checks = 0;
    pvd_image_decode #(.FIFO_DEPTH(16)) dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr, .pci_valid, .pci_ready, .pci_claim, .pci_addr, .pci_io_space, .pci_write, .pci_wdata,
        .vme_valid, .vme_ready, .vme_addr, .vme_wdata, .vme_write, .vme_posted, .vme_width, .vme_space,
        .vme_program, .vme_supervisor, .vme_blt_ok, .vme_mblt_ok, .vme_image);
    pvd_pci_master m (.clk(pclk), .pci_ready, .pci_claim, .pci_valid, .pci_addr, .pci_io_space, .pci_write,
        .pci_wdata);
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
        checks++;
        if (s !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic er);
        apb(a, 1'b0, 32'h0);
        chk("prdata", rd_q, e);
        chk("pslverr", err_q, er);
    endtask
    task automatic req(input logic [31:0] a, input logic io, input logic w, input logic e);
        m.issue(a, io, w, ~a, 8);
        chk("pci_claim", m.hit, e);
    endtask
    task automatic pop(input logic [31:0] a, input logic [11:0] f, input logic [31:0] d);
        vme_ready <= 1'b1;
        do @(negedge pclk); while (vme_valid !== 1'b1);
        chk("vme_addr", vme_addr, a);
        chk("vme_wdata", vme_wdata, d);
        chk("vme_flags", {vme_write, vme_posted, vme_width, vme_space, vme_program, vme_supervisor, vme_blt_ok,
            vme_mblt_ok, vme_image}, f);
        @(posedge pclk);
        vme_ready <= 1'b0;
        @(posedge pclk);
    endtask
    function automatic logic [31:0] cw(input logic en, pw, input logic [1:0] w, input logic [2:0] s,
        input logic p, su, v, l);
        cw = 32'h0;
        cw[PVD_CTL_EN_BIT] = en;
        cw[PVD_CTL_POSTED_WRITE_ON_BIT] = pw;
        cw[PVD_CTL_VDW_LSB+:2] = w;
        cw[PVD_CTL_VAS_LSB+:3] = s;
        cw[PVD_CTL_PGM_BIT] = p;
        cw[PVD_CTL_SUPER_BIT] = su;
        cw[PVD_CTL_VCT_BIT] = v;
        cw[PVD_CTL_LAS_BIT] = l;
    endfunction
    task automatic t_reset;
        for (int i = 0; i < 8; i++) rd(OFFS[i], (i % 4 == 3) ? 32'h0080_0000 : 32'h0, 1'b0);
        rd(12'h1FC, 32'h0, 1'b1);
        rd(12'h129, 32'h0, 1'b1);
        $display("test reset values done");
    endtask
    task automatic t_regs;
        for (int i = 0; i < 8; i++) begin
            apb(OFFS[i], 1'b1, 32'hFFFF_FFFF);
            rd(OFFS[i], (i % 4 == 3) ? 32'hC0C7_5101 : 32'hFFFF_0000, 1'b0);
        end
        $display("test register access done");
    endtask
    task automatic t_window;
        apb(PVD_OFF_IMG2_BASE, 1'b1, 32'h1000_0000);
        apb(PVD_OFF_IMG2_BOUND, 1'b1, 32'h1002_0000);
        apb(PVD_OFF_IMG2_XLAT, 1'b1, 32'h0100_0000);
        apb(PVD_OFF_IMG2_CTL, 1'b1, cw(1'b1, 1'b1, PVD_W64, PVD_A32, 1'b1, 1'b1, 1'b0, 1'b0));
        req(32'h0FFF_FFFC, 1'b0, 1'b1, 1'b0);
        req(32'h1000_0000, 1'b0, 1'b1, 1'b1);
        req(32'h1001_ABCD, 1'b0, 1'b1, 1'b1);
        req(32'h1002_0000, 1'b0, 1'b1, 1'b0);
        // Two misses counted, two entries queued, last taken request was a miss
        rd(PVD_OFF_STATUS, 32'h0002_0200, 1'b0);
        pop(32'h1100_0000, {2'b11, PVD_W64, PVD_A32, 5'b11010},
            ~32'h1000_0000);
        pop(32'h1101_ABCD, {2'b11, PVD_W64, PVD_A32, 5'b11010},
            ~32'h1001_ABCD);
        $display("test image window done");
    endtask
    task automatic t_io;
        apb(PVD_OFF_IMG3_BASE, 1'b1, 32'hF000_0000);
        apb(PVD_OFF_IMG3_XLAT, 1'b1, 32'h2000_0000);
        apb(PVD_OFF_IMG3_CTL, 1'b1, cw(1'b1, 1'b1, PVD_W16, PVD_A24, 1'b0, 1'b0, 1'b1, 1'b1));
        req(32'hEFFF_FFFF, 1'b1, 1'b1, 1'b0);
        req(32'hFFFF_0010, 1'b0, 1'b1, 1'b0);
        req(32'hFFFF_0010, 1'b1, 1'b1, 1'b1);
        pop(32'h1FFF_0010, {2'b10, PVD_W16, PVD_A24, 5'b00101}, ~32'hFFFF_0010);
        apb(PVD_OFF_IMG2_CTL, 1'b1, 32'h0);
        req(32'h1000_0000, 1'b0, 1'b1, 1'b0);
        apb(PVD_OFF_IMG3_CTL, 1'b1, cw(1'b1, 1'b0, PVD_W32, PVD_RSV3, 1'b0, 1'b0, 1'b0, 1'b1));
        req(32'hFFFF_0010, 1'b1, 1'b0, 1'b0);
        apb(PVD_OFF_IMG3_CTL, 1'b1, cw(1'b1, 1'b0, PVD_W32, PVD_RSV4, 1'b0, 1'b0, 1'b0, 1'b1));
        req(32'hFFFF_0010, 1'b1, 1'b0, 1'b0);
        $display("test io and disable done");
    endtask
    task automatic t_codes;
        logic [2:0] sp [6] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6, 3'h7};
        logic [2:0] s;
        logic [1:0] w;
        logic b;
        for (int i = 0; i < 24; i++) begin
            s = sp[i / 4];
            w = i[1:0];
            b = (s == 3'h1 || s == 3'h2);
            apb(PVD_OFF_IMG2_CTL, 1'b1, cw(1'b1, 1'b0, w, s, 1'b0, 1'b0, s[0], 1'b0));
            rd(PVD_OFF_IMG2_CTL, cw(1'b1, 1'b0, w, s, 1'b0, 1'b0, s[0], 1'b0), 1'b0);
            req(32'h1000_0040, 1'b0, 1'b0, 1'b1);
            pop(32'h1100_0040, {2'b00, w, s, 2'b00, b & s[0] & (w != 2'h3), b & (w == 2'h3), 1'b0},
                ~32'h1000_0040);
        end
        $display("test width and space codes done");
    endtask
    task automatic t_fifo;
        apb(PVD_OFF_IMG2_CTL, 1'b1, cw(1'b1, 1'b0, PVD_W32, PVD_A32, 1'b0, 1'b0, 1'b0, 1'b0));
        for (int i = 0; i <= 16; i++) begin
            m.issue(32'h1000_0000 + 32'(i * 4), 1'b0, 1'b1, 32'(i), 4);
            chk("pci_taken", m.took, i < 16);
        end
        for (int i = 0; i < 16; i++) pop(32'h1100_0000 + 32'(i * 4), {2'b10, PVD_W32, PVD_A32, 5'b0}, 32'(i));
        @(negedge pclk);
        chk("vme_valid", vme_valid, 1'b0);
        $display("test queue fill and drain done");
    endtask
    task automatic do_reset;
        presetn <= 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask
    task automatic end_of_test;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        end_of_test();
    end
    initial begin
        {psel, penable, pwrite, vme_ready} = 4'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        do_reset();
        t_reset();
        t_regs();
        do_reset();
        t_reset();
        t_window();
        t_io();
        t_codes();
        t_fifo();
        end_of_test();
    end
endmodule

//--- pvd_image_decode_chk.sv
// Checker: port-level properties of the image decoder, bound to its top module
`timescale 1ns/100ps
module pvd_image_decode_chk #(
    parameter int FIFO_DEPTH = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pslverr,
    input wire logic pci_valid,
    input wire logic pci_ready,
    input wire logic pci_claim,
    input wire logic [31:0] pci_addr,
    input wire logic pci_io_space,
    input wire logic vme_valid,
    input wire logic vme_ready,
    input wire logic [31:0] vme_addr,
    input wire logic vme_write,
    input wire logic vme_posted,
    input wire logic [1:0] vme_width,
    input wire logic [2:0] vme_space,
    input wire logic vme_blt_ok,
    input wire logic vme_mblt_ok
);
    logic cfg_reg;
    int cnt_reg;
    // Shadow fill count; a plain flag would miss an off-by-one at full
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_reg <= 1'b0;
            cnt_reg <= 0;
        end else begin
            cfg_reg <= cfg_reg | (psel & penable & pwrite);
            cnt_reg <= cnt_reg + int'(pci_valid & pci_ready & pci_claim) - int'(vme_valid & vme_ready);
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence push_s;
        pci_valid && pci_ready && pci_claim && !vme_valid;
    endsequence
    reset_quiet_a: assert property ($rose(presetn) |-> !vme_valid && !pci_claim)
        else $error("queue or claim live after reset");
    no_claim_a: assert property (!cfg_reg |-> !pci_claim)
        else $error("claim while no image enabled");
    low_pass_a: assert property (push_s |=> vme_valid && vme_addr[15:0] == $past(pci_addr[15:0]))
        else $error("low address bits altered");
    io_coupled_a: assert property (push_s ##0 pci_io_space |=> !vme_posted)
        else $error("io access posted");
    posted_write_a: assert property (vme_valid && vme_posted |-> vme_write)
        else $error("posted read");
    blt_gate_a: assert property (vme_valid && vme_blt_ok |-> vme_space inside {3'h1, 3'h2} && vme_width != 2'h3)
        else $error("block transfer outside A24/A32 narrow");
    mblt_space_a: assert property (vme_valid && vme_space inside {3'h1, 3'h2} |-> vme_mblt_ok == (vme_width == 2'h3))
        else $error("wide block flag wrong");
    space_legal_a: assert property (vme_valid |-> !(vme_space inside {3'h3, 3'h4}))
        else $error("reserved space forwarded");
    fifo_full_a: assert property (pci_valid && pci_claim && cnt_reg == FIFO_DEPTH |-> !pci_ready)
        else $error("hit taken while queue full");
    head_hold_a: assert property (vme_valid && !vme_ready |=> vme_valid && $stable(vme_addr))
        else $error("queue head changed unpopped");
    err_phase_a: assert property (pslverr |-> psel && penable)
        else $error("error outside access phase");
endmodule
bind pvd_image_decode pvd_image_decode_chk #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
    .pslverr, .pci_valid, .pci_ready, .pci_claim, .pci_addr, .pci_io_space, .vme_valid, .vme_ready, .vme_addr,
    .vme_write, .vme_posted, .vme_width, .vme_space, .vme_blt_ok, .vme_mblt_ok);

//--- pvd_pci_master.sv
// Partner model: PCI-side master offering one access at a time
`timescale 1ns/100ps
module pvd_pci_master (
    input wire logic clk,
    input wire logic pci_ready,
    input wire logic pci_claim,
    output logic pci_valid,
    output logic [31:0] pci_addr,
    output logic pci_io_space,
    output logic pci_write,
    output logic [31:0] pci_wdata
);
    logic took;
    logic hit;
    initial begin
        pci_valid = 1'b0;
        pci_addr = 32'h0;
        pci_io_space = 1'b0;
        pci_write = 1'b0;
        pci_wdata = 32'h0;
    end
    // Holds the request until taken; gives up after lim cycles so a refusal can be seen
    task automatic issue(input logic [31:0] a, input logic io, input logic w, input logic [31:0] d, input int lim);
        int n;
        n = 0;
        took = 1'b0;
        pci_valid <= 1'b1;
        pci_addr <= a;
        pci_io_space <= io;
        pci_write <= w;
        pci_wdata <= d;
        while (!took && n < lim) begin
            @(negedge clk);
            took = (pci_ready === 1'b1);
            hit = pci_claim;
            n++;
            @(posedge clk);
        end
        // A released bus shows the inverse of its last value, never a stale copy
        pci_valid <= 1'b0;
        pci_addr <= ~a;
        pci_io_space <= ~io;
        pci_write <= ~w;
        pci_wdata <= ~d;
        @(posedge clk);
    endtask
endmodule

//--- pvd_pkg.sv
// Package: register map, field layout, encodings and types for the PCI-to-VME image decoder
package pvd_pkg;

    // Register byte offsets
    localparam logic [11:0] PVD_OFF_IMG2_CTL = 12'h128;
    localparam logic [11:0] PVD_OFF_IMG2_BASE = 12'h12C;
    localparam logic [11:0] PVD_OFF_IMG2_BOUND = 12'h130;
    localparam logic [11:0] PVD_OFF_IMG2_XLAT = 12'h134;
    localparam logic [11:0] PVD_OFF_IMG3_CTL = 12'h13C;
    localparam logic [11:0] PVD_OFF_IMG3_BASE = 12'h140;
    localparam logic [11:0] PVD_OFF_IMG3_BOUND = 12'h144;
    localparam logic [11:0] PVD_OFF_IMG3_XLAT = 12'h148;
    localparam logic [11:0] PVD_OFF_STATUS = 12'h1F0;

    // Control word field positions
    localparam int PVD_CTL_EN_BIT = 31;
    localparam int PVD_CTL_POSTED_WRITE_ON_BIT = 30;
    localparam int PVD_CTL_VDW_LSB = 22;
    localparam int PVD_CTL_VAS_LSB = 16;
    localparam int PVD_CTL_PGM_BIT = 14;
    localparam int PVD_CTL_SUPER_BIT = 12;
    localparam int PVD_CTL_VCT_BIT = 8;
    localparam int PVD_CTL_LAS_BIT = 0;

    // Base, bound and offset fields hold address bits 31..16 (64 KB steps)
    localparam int PVD_HI_LSB = 16;

    // Status word field positions
    localparam int PVD_ST_MISS_LSB = 16;
    localparam int PVD_ST_LEVEL_LSB = 8;
    localparam int PVD_ST_HIT_LSB = 0;

    typedef enum logic [1:0] {
        PVD_W8 = 2'b00,
        PVD_W16 = 2'b01,
        PVD_W32 = 2'b10,
        PVD_W64 = 2'b11
    } pvd_width_t;

    typedef enum logic [2:0] {
        PVD_A16 = 3'b000,
        PVD_A24 = 3'b001,
        PVD_A32 = 3'b010,
        PVD_RSV3 = 3'b011,
        PVD_RSV4 = 3'b100,
        PVD_CRCSR = 3'b101,
        PVD_USER1 = 3'b110,
        PVD_USER2 = 3'b111
    } pvd_space_t;

    typedef struct packed {
        logic en;
        logic posted_write_on;
        pvd_width_t vme_max_width;
        pvd_space_t vme_space_select;
        logic program_modifier_bit;
        logic super_mode;
        logic block_cycle_allow;
        logic pci_space_select;
        logic [15:0] base;
        logic [15:0] bound;
        logic [15:0] xlat;
    } pvd_img_t;

    localparam pvd_img_t PVD_IMG_RESET = '{
        en: 1'b0, posted_write_on: 1'b0, vme_max_width: PVD_W32, vme_space_select: PVD_A16, program_modifier_bit: 1'b0, super_mode: 1'b0,
        block_cycle_allow: 1'b0, pci_space_select: 1'b0, base: 16'h0000, bound: 16'h0000, xlat: 16'h0000
    };

    // One forwarded access as it waits for the VME master
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
        logic write;
        logic posted;
        pvd_width_t width;
        pvd_space_t space;
        logic program_am;
        logic supervisor_am;
        logic blt_ok;
        logic mblt_ok;
        logic image;
    } pvd_fwd_t;

    localparam int PVD_FIFO_DEPTH = 16;

endpackage
